/* sbsp_pkg.sv */
// Purpose: Shared constants and types for the synchronous burst SRAM port
// Assumes: 50 MHz clock, lanes of eight data bits plus one parity bit
// Notes:   Timing counts derive from times given in nanoseconds
`default_nettype none
package sbsp_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 20;
    localparam int unsigned LANE_DATA_BITS = 8;
    localparam int unsigned LANE_BITS      = 9;      // Eight data bits and one parity bit
    localparam int unsigned LANES_DEFAULT  = 4;      // Four lanes gives the 36-bit bus
    localparam int unsigned ADDR_DEFAULT   = 8;
    localparam int unsigned FIFO_DEPTH     = 8;
    localparam int unsigned SLEEP_CYC      = 2;      // Sleep entry within two clock cycles
    localparam int unsigned SLEEP_NS       = SLEEP_CYC * CLK_PERIOD_NS;
    localparam int unsigned SLEEP_CNT      = (SLEEP_NS / CLK_PERIOD_NS < 1) ? 1 : SLEEP_NS / CLK_PERIOD_NS;
    localparam logic [1:0]  BURST_STEP     = 2'h1;
    localparam logic [1:0]  RST_SYNC_INIT  = 2'h0;

    typedef enum logic [1:0] {
        SBSP_OP_IDLE,
        SBSP_OP_READ,
        SBSP_OP_WRITE
    } sbsp_op_e;
endpackage
`default_nettype wire

/* sbsp_wr_if.sv */
// Purpose: Carrier for write beats between the port and the array
// Assumes: One clock domain
// Notes:   Valid and ready form the usual handshake
`timescale 1ns/1ps
`default_nettype none
interface sbsp_wr_if #(
    parameter int unsigned AW = 8,
    parameter int unsigned DW = 36,
    parameter int unsigned NL = 4
);
    logic          valid;
    logic          ready;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic [NL-1:0] lane_en;

    modport src (output valid, output addr, output data, output lane_en, input ready);
    modport snk (input valid, input addr, input data, input lane_en, output ready);
endinterface
`default_nettype wire

/* sbsp_fifo.sv */
// Purpose: Write-beat FIFO between the bus port and the storage array
// Assumes: Single clock, synchronous handshake both sides
// Notes:   Full and empty are exact; depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module sbsp_fifo #(
    parameter int unsigned WIDTH = 48,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW:0]      wp_q, wp_d, rp_q, rp_d;
    logic             push, pop;

    // Pointer next values; extra bit tells full from empty
    always_comb begin
        in_ready_o  = (wp_q - rp_q) != (PW+1)'(DEPTH);
        out_valid_o = wp_q != rp_q;
        push        = in_valid_i && in_ready_o;
        pop         = out_valid_o && out_ready_i;
        wp_d        = push ? wp_q + 1'b1 : wp_q;
        rp_d        = pop ? rp_q + 1'b1 : rp_q;
        out_data_o  = mem_q[rp_q[PW-1:0]];
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    // Storage has no reset to stay cheap
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wp_q[PW-1:0]] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

/* sbsp_array.sv */
// Purpose: Lane-masked storage array for the SRAM port
// Assumes: Write beats arrive through the carrier interface
// Notes:   Reads are combinational so data flows through in one cycle
`timescale 1ns/1ps
`default_nettype none
module sbsp_array #(
    parameter int unsigned AW = 8,
    parameter int unsigned NL = 4
) (
    input  wire logic                clk_i,
    sbsp_wr_if.snk                   wr,
    input  wire logic [AW-1:0]       rd_addr_i,
    output logic      [NL*9-1:0]     rd_data_o
);
    localparam int unsigned LB = sbsp_pkg::LANE_BITS;

    assign wr.ready = 1'b1;

    // One storage column per lane, so every lane owns its write process
    // and unselected lanes keep their contents
    for (genvar l = 0; l < NL; l++) begin : g_lane
        logic [LB-1:0] lane_mem_q [2**AW];
        always_ff @(posedge clk_i) begin
            if (wr.valid && wr.lane_en[l]) begin
                lane_mem_q[wr.addr] <= wr.data[l*LB +: LB];
            end
        end
        assign rd_data_o[l*LB +: LB] = lane_mem_q[rd_addr_i];
    end
endmodule
`default_nettype wire

/* sbsp_top.sv */
// Purpose: Command decode, burst control and data-pin control of a flow-through burst SRAM
// Assumes: All synchronous inputs sampled on clk_i; output enable acts combinationally
// Notes:   Write data goes through a FIFO to the array; a full FIFO refuses write beats
`timescale 1ns/1ps
`default_nettype none
module sbsp_top #(
    parameter int unsigned ADDR_W = sbsp_pkg::ADDR_DEFAULT,
    parameter int unsigned LANES  = sbsp_pkg::LANES_DEFAULT,
    parameter int unsigned DW     = LANES * sbsp_pkg::LANE_DATA_BITS
) (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              clk_qualify_n_i,
    input  wire logic              chip_sel_a_n_i,
    input  wire logic              chip_sel_b_i,
    input  wire logic              chip_sel_c_n_i,
    input  wire logic              sleep_req_i,
    input  wire logic              advance_load_n_i,
    input  wire logic              write_n_i,
    input  wire logic              out_en_n_i,
    input  wire logic              burst_order_i,
    input  wire logic [LANES-1:0]  lane_wr_sel_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DW-1:0]     data_i,
    output logic      [DW-1:0]     data_o,
    output logic      [DW-1:0]     data_oe_o,
    input  wire logic [LANES-1:0]  parity_io_i,
    output logic      [LANES-1:0]  parity_io_o,
    output logic      [LANES-1:0]  parity_io_oe_o,
    output logic                   write_ready_o,
    output logic                   asleep_o
);
    localparam int unsigned LB = sbsp_pkg::LANE_BITS;
    localparam int unsigned DB = sbsp_pkg::LANE_DATA_BITS;
    localparam int unsigned FW = ADDR_W + LANES + LANES * LB;
    localparam int unsigned SW = $clog2(sbsp_pkg::SLEEP_CNT + 1);

    // Reset release through two flops
    logic [1:0] rst_sync_q;
    logic       rst_b;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_q <= sbsp_pkg::RST_SYNC_INIT;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_q[1];

    // Control state
    sbsp_pkg::sbsp_op_e op_q, op_d;
    logic [ADDR_W-1:0]  base_q, base_d;     // Address captured at burst start
    logic [1:0]         cnt_q, cnt_d;       // Burst step count
    logic               order_q, order_d;   // Burst order latched at start
    logic               wr_pend_q, wr_pend_d;
    logic [ADDR_W-1:0]  wr_addr_q, wr_addr_d;
    logic [SW-1:0]      slp_cnt_q, slp_cnt_d;
    logic               asleep_q, asleep_d;
    logic [LANES*LB-1:0] rd_word_q, rd_word_d;

    logic              qual, sel_all, start, cont;
    logic [1:0]        low_bits;
    logic [ADDR_W-1:0] cur_addr;
    logic [LANES*LB-1:0] arr_rd, wr_word;
    logic              fifo_in_ready, fifo_out_valid;
    logic [FW-1:0]     fifo_out;

    sbsp_wr_if #(.AW(ADDR_W), .DW(LANES*LB), .NL(LANES)) wr_bus ();

    // Merge lane data and parity into the stored word layout
    for (genvar l = 0; l < LANES; l++) begin : g_pack
        assign wr_word[l*LB +: LB] = {parity_io_i[l], data_i[l*DB +: DB]};
    end

    // Burst address: linear adds the step, interleaved xors it. Built from
    // the next values, so the word registered at a read edge is the one
    // that edge asked for
    always_comb begin
        low_bits = order_d ? (base_d[1:0] ^ cnt_d) : (base_d[1:0] + cnt_d);
        cur_addr = {base_d[ADDR_W-1:2], low_bits};
    end

    // Command decode and next-state logic
    always_comb begin
        qual      = !clk_qualify_n_i && !asleep_q;
        sel_all   = !chip_sel_a_n_i && chip_sel_b_i && !chip_sel_c_n_i;
        start     = qual && !advance_load_n_i && sel_all;
        cont      = qual && advance_load_n_i;
        op_d      = op_q;
        base_d    = base_q;
        cnt_d     = cnt_q;
        order_d   = order_q;
        wr_pend_d = wr_pend_q;
        wr_addr_d = wr_addr_q;
        if (qual) begin
            wr_pend_d = 1'b0;
            if (!advance_load_n_i) begin
                if (sel_all) begin
                    base_d  = addr_i;
                    cnt_d   = 2'h0;
                    order_d = burst_order_i;
                    op_d    = write_n_i ? sbsp_pkg::SBSP_OP_READ
                                        : sbsp_pkg::SBSP_OP_WRITE;
                end else begin
                    op_d = sbsp_pkg::SBSP_OP_IDLE;
                end
            end else if (op_q != sbsp_pkg::SBSP_OP_IDLE) begin
                cnt_d = cnt_q + sbsp_pkg::BURST_STEP;
            end
            if (op_d == sbsp_pkg::SBSP_OP_WRITE) begin
                wr_pend_d = 1'b1;
                wr_addr_d = start ? addr_i : {base_q[ADDR_W-1:2],
                    order_q ? (base_q[1:0] ^ (cnt_q + sbsp_pkg::BURST_STEP))
                            : (base_q[1:0] + cnt_q + sbsp_pkg::BURST_STEP)};
            end
        end else if (asleep_q) begin
            op_d      = sbsp_pkg::SBSP_OP_IDLE;
            wr_pend_d = 1'b0;
        end
    end

    // Read data group: a read start or step loads the array word; a dummy
    // read loads it as well, only the drivers stay off
    always_comb begin
        rd_word_d = rd_word_q;
        if ((cont && op_q == sbsp_pkg::SBSP_OP_READ) || (start && write_n_i)) begin
            rd_word_d = arr_rd;
        end
    end

    // Sleep entry counter; pins go quiet at once, state settles in two cycles
    always_comb begin
        slp_cnt_d = slp_cnt_q;
        asleep_d  = asleep_q;
        if (sleep_req_i) begin
            if (slp_cnt_q < SW'(sbsp_pkg::SLEEP_CNT - 1)) begin
                slp_cnt_d = slp_cnt_q + 1'b1;
            end else begin
                asleep_d = 1'b1;
            end
        end else begin
            slp_cnt_d = '0;
            asleep_d  = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            op_q      <= sbsp_pkg::SBSP_OP_IDLE;
            base_q    <= '0;
            cnt_q     <= 2'h0;
            order_q   <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            slp_cnt_q <= '0;
            asleep_q  <= 1'b0;
            rd_word_q <= '0;
        end else begin
            op_q      <= op_d;
            base_q    <= base_d;
            cnt_q     <= cnt_d;
            order_q   <= order_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            slp_cnt_q <= slp_cnt_d;
            asleep_q  <= asleep_d;
            rd_word_q <= rd_word_d;
        end
    end

    // Write beat completes on the edge after the command; an all-high select
    // pattern pushes nothing so no location changes
    logic push_beat;
    assign push_beat     = wr_pend_q && !clk_qualify_n_i && !(&lane_wr_sel_n_i);
    assign write_ready_o = fifo_in_ready;

    sbsp_fifo #(
        .WIDTH(FW),
        .DEPTH(sbsp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b),
        .in_valid_i  (push_beat),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   ({wr_addr_q, ~lane_wr_sel_n_i, wr_word}),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (wr_bus.ready),
        .out_data_o  (fifo_out)
    );

    assign wr_bus.valid   = fifo_out_valid;
    assign wr_bus.addr    = fifo_out[FW-1 -: ADDR_W];
    assign wr_bus.lane_en = fifo_out[LANES*LB +: LANES];
    assign wr_bus.data    = fifo_out[LANES*LB-1:0];

    sbsp_array #(
        .AW(ADDR_W),
        .NL(LANES)
    ) u_array (
        .clk_i     (clk_i),
        .wr        (wr_bus),
        .rd_addr_i (cur_addr),
        .rd_data_o (arr_rd)
    );

    // Drivers: current read cycle and live output enable only; writes,
    // deselect, reset and sleep all force tri-state
    logic drive;
    assign drive = (op_q == sbsp_pkg::SBSP_OP_READ) && !out_en_n_i
                 && !wr_pend_q && !sleep_req_i && !asleep_q;
    for (genvar l = 0; l < LANES; l++) begin : g_out
        assign data_o[l*DB +: DB]    = rd_word_q[l*LB +: DB];
        assign parity_io_o[l]        = rd_word_q[l*LB + DB];
        assign data_oe_o[l*DB +: DB] = {DB{drive}};
        assign parity_io_oe_o[l]     = drive;
    end
    assign asleep_o = asleep_q;
endmodule
`default_nettype wire

/* sbsp_properties.sv */
// Purpose: Port properties of the burst SRAM port
// Assumes: One clock, active-low reset
// Notes:   Drive enables are judged as sampled at the rising edge
`timescale 1ns/1ps
`default_nettype none
module sbsp_properties #(
    parameter int unsigned LANES = 4,
    parameter int unsigned DW    = 32
) (
    input wire logic             clk_i,
    input wire logic             rst_b_i,
    input wire logic             clk_qualify_n_i,
    input wire logic             chip_sel_a_n_i,
    input wire logic             chip_sel_b_i,
    input wire logic             chip_sel_c_n_i,
    input wire logic             sleep_req_i,
    input wire logic             advance_load_n_i,
    input wire logic             write_n_i,
    input wire logic             out_en_n_i,
    input wire logic [DW-1:0]    data_o,
    input wire logic [DW-1:0]    data_oe_o,
    input wire logic [LANES-1:0] parity_io_oe_o,
    input wire logic             asleep_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Acting edge with a new command, full selection, any driver on
    wire go  = !clk_qualify_n_i && !sleep_req_i && !asleep_o && !advance_load_n_i;
    wire sel = !chip_sel_a_n_i && chip_sel_b_i && !chip_sel_c_n_i;
    wire drv = |{data_oe_o, parity_io_oe_o};
    sequence rd_go; go && sel && write_n_i; endsequence
    sequence wr_go; go && sel && !write_n_i; endsequence
    sequence desel_go; go && !sel ##1 advance_load_n_i; endsequence
    oe_gate_a: assert property (out_en_n_i |-> !drv)
        else $error("driven with enable off");
    sleep_off_a: assert property (sleep_req_i |-> !drv)
        else $error("driven in sleep");
    write_off_a: assert property (wr_go |=> !drv)
        else $error("driven in write");
    read_on_a: assert property (rd_go ##1 (!out_en_n_i && !sleep_req_i) |-> &{data_oe_o, parity_io_oe_o})
        else $error("read not driven");
    desel_off_a: assert property (desel_go |=> !drv)
        else $error("driven while deselected");
    stall_hold_a: assert property (clk_qualify_n_i && !sleep_req_i && !asleep_o |=> $stable(data_o))
        else $error("data moved on stall");
    reset_idle_a: assert property ($rose(rst_b_i) |-> !drv [*3])
        else $error("driven after reset");
    sleep_in_a: assert property (sleep_req_i [*3] |-> asleep_o)
        else $error("sleep late");
endmodule
bind sbsp_top sbsp_properties #(.LANES(LANES), .DW(DW)) u_props (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .clk_qualify_n_i(clk_qualify_n_i), .chip_sel_a_n_i(chip_sel_a_n_i), .chip_sel_b_i(chip_sel_b_i),
    .chip_sel_c_n_i(chip_sel_c_n_i), .sleep_req_i(sleep_req_i), .advance_load_n_i(advance_load_n_i),
    .write_n_i(write_n_i), .out_en_n_i(out_en_n_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .parity_io_oe_o(parity_io_oe_o), .asleep_o(asleep_o));
`default_nettype wire

/* sbsp_ctrl_model.sv */
// Purpose: Memory controller model facing the port pins
// Assumes: Fields change at the falling edge only
// Notes:   A released line shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module sbsp_ctrl_model #(
    parameter int unsigned AW = 8,
    parameter int unsigned NL = 4
) (
    input  wire logic            clk_i,
    input  wire logic [NL*9-1:0] q_i,
    input  wire logic [NL*9-1:0] qoe_i,
    output logic      [NL*9-1:0] dq_o,
    output logic                 qual_n_o,
    output logic      [2:0]      cs_o,
    output logic                 ld_n_o,
    output logic                 wr_n_o,
    output logic      [NL-1:0]   bw_n_o,
    output logic      [AW-1:0]   a_o
);
    logic [NL*9-1:0] hold_q;
    logic [NL*9-1:0] wd;
    logic            dv;
    // No pull on the bus, so a floating line must not look clean
    assign dq_o = (qoe_i & q_i) | (~qoe_i & (dv ? wd : ~hold_q));
    always @(posedge clk_i) hold_q <= dq_o;
    initial begin
        {hold_q, wd, dv, qual_n_o, ld_n_o, wr_n_o, a_o} = '0;
        cs_o = 3'h3;
        bw_n_o = '1;
    end
    // One bus cycle: a command plus the data of the previous write
    task automatic beat(input logic [2:0] cs, input logic ld_n, input logic wr_n, input logic [NL-1:0] bw,
                        input logic [AW-1:0] a, input logic drv, input logic [NL*9-1:0] d);
        cs_o = cs;
        ld_n_o = ld_n;
        wr_n_o = wr_n;
        a_o = a;
        bw_n_o = bw;
        dv = drv;
        wd = d;
        @(posedge clk_i);
        @(negedge clk_i);
    endtask
    // Hold every field across one ignored edge
    task automatic stall();
        qual_n_o = 1'b1;
        @(posedge clk_i);
        @(negedge clk_i);
        qual_n_o = 1'b0;
    endtask
endmodule
`default_nettype wire

/* tb_sync_burst_sram_port.sv */
// Purpose: Self-checking bench for the burst SRAM port
// Assumes: Controller model moves pins at the falling edge
// Notes:   Words are compared as {parity, data}
`timescale 1ns/1ps
`default_nettype none
module tb_sync_burst_sram_port;
    localparam logic [2:0] ON  = 3'h2; // All three selects active
    localparam logic [2:0] OFF = 3'h3;
    logic            clk   = 1'b0;
    logic            rst_b = 1'b0;
    logic            oe_n  = 1'b0;
    logic            zz    = 1'b0;
    logic            ord   = 1'b0;
    wire logic [2:0] cs;
    wire logic       qn;
    wire logic       ld_n;
    wire logic       wr_n;
    wire logic       rdy;
    wire logic       slp;
    wire logic [3:0] bw_n;
    wire logic [3:0] pin;
    wire logic [3:0] pq;
    wire logic [3:0] poe;
    wire logic [7:0] a;
    wire logic [31:0] din;
    wire logic [31:0] q;
    wire logic [31:0] qoe;
    logic [35:0]     bk [4];
    int              num_errors = 0;
    int              checked = 0;
    always #10 clk = ~clk;
    sbsp_top dut (.clk_i(clk), .rst_b_i(rst_b), .clk_qualify_n_i(qn), .chip_sel_a_n_i(cs[0]),
        .chip_sel_b_i(cs[1]), .chip_sel_c_n_i(cs[2]), .sleep_req_i(zz), .advance_load_n_i(ld_n),
        .write_n_i(wr_n), .out_en_n_i(oe_n), .burst_order_i(ord), .lane_wr_sel_n_i(bw_n), .addr_i(a),
        .data_i(din), .data_o(q), .data_oe_o(qoe), .parity_io_i(pin), .parity_io_o(pq),
        .parity_io_oe_o(poe), .write_ready_o(rdy), .asleep_o(slp));
    sbsp_ctrl_model pm (.clk_i(clk), .q_i({pq, q}), .qoe_i({poe, qoe}), .dq_o({pin, din}), .qual_n_o(qn),
        .cs_o(cs), .ld_n_o(ld_n), .wr_n_o(wr_n), .bw_n_o(bw_n), .a_o(a));
    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) pm.beat(OFF, 1'b0, 1'b1, 4'hf, 8'h00, 1'b0, 36'h0);
    endtask
    // Write, then a few idle cycles so the FIFO reaches the array
    task automatic wr1(input logic [7:0] ad, input logic [35:0] d, input logic [3:0] m);
        pm.beat(ON, 1'b0, 1'b0, m, ad, 1'b0, 36'h0);
        chk("write oe", {poe, qoe}, 36'h0);
        pm.beat(OFF, 1'b0, 1'b1, m, 8'h00, 1'b1, d);
        chk("write ready", {35'h0, rdy}, 36'h1);
        idle(3);
    endtask
    // Lane selects are left low on a read to show they are ignored
    task automatic rd1(input logic [7:0] ad, input logic [35:0] e);
        pm.beat(ON, 1'b0, 1'b1, 4'h0, ad, 1'b0, 36'h0);
        chk("read data", {pq, q}, e);
        chk("read oe", {poe, qoe}, 36'hF_FFFF_FFFF);
        idle(1);
    endtask
    task automatic t_reset();
        chk("reset oe", {poe, qoe}, 36'h0);
    endtask
    task automatic t_lanes();
        logic [35:0] e;
        for (int m = 0; m < 16; m++) begin
            wr1(8'h10, 36'hF_FFFF_FFFF, 4'h0);
            wr1(8'h10, 36'h0, 4'(m));
            for (int l = 0; l < 4; l++) begin
                e[l*8+:8] = m[l] ? 8'hff : 8'h00;
                e[32+l] = m[l];
            end
            rd1(8'h10, e);
        end
    endtask
    // Linear write burst with an empty beat, interleaved read with a stall
    task automatic t_burst();
        logic [35:0] ex [4];
        wr1(8'h20, 36'h0, 4'h0);
        pm.beat(ON, 1'b0, 1'b0, 4'h0, 8'h22, 1'b0, 36'h0);
        for (int k = 0; k < 4; k++) begin
            bk[k] = {4'(k), 32'h5A00_0000 + 32'(k)};
            pm.beat(k < 3 ? 3'h5 : OFF, k < 3, 1'b1, k == 2 ? 4'hf : 4'h0, 8'h00, 1'b1, bk[k]);
        end
        idle(3);
        ord = 1'b1;
        ex = '{bk[3], 36'h0, bk[1], bk[0]};
        pm.beat(ON, 1'b0, 1'b1, 4'hf, 8'h21, 1'b0, 36'h0);
        for (int k = 0; k < 4; k++) begin
            chk("burst read", {pq, q}, ex[k]);
            if (k == 0) begin
                pm.stall();
                chk("stall", {pq, q}, ex[0]);
            end
            pm.beat(k < 3 ? 3'h5 : OFF, k < 3, 1'b0, 4'hf, 8'h00, 1'b0, 36'h0);
        end
        oe_n = 1'b1;
        pm.beat(ON, 1'b0, 1'b1, 4'hf, 8'h22, 1'b0, 36'h0);
        chk("dummy oe", {poe, qoe}, 36'h0);
        oe_n = 1'b0;
        pm.beat(3'h5, 1'b1, 1'b1, 4'hf, 8'h00, 1'b0, 36'h0);
        chk("after dummy", {pq, q}, bk[1]);
        idle(1);
    endtask
    // Each select alone deselects; load high keeps it deselected
    task automatic t_desel();
        for (int i = 0; i < 3; i++) begin
            pm.beat(ON, 1'b0, 1'b1, 4'hf, 8'h23, 1'b0, 36'h0);
            pm.beat(ON ^ (3'h1 << i), 1'b0, 1'b1, 4'hf, 8'h23, 1'b0, 36'h0);
            chk("deselect", {poe, qoe}, 36'h0);
            pm.beat(ON, 1'b1, 1'b1, 4'hf, 8'h23, 1'b0, 36'h0);
            chk("keep deselect", {poe, qoe}, 36'h0);
        end
    endtask
    // Deselected first, then sleep; contents survive it
    task automatic t_sleep();
        idle(1);
        zz = 1'b1;
        idle(2);
        chk("asleep", {35'h0, slp}, 36'h1);
        idle(2);
        zz = 1'b0;
        idle(4);
        rd1(8'h23, bk[1]);
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        t_reset();
        t_lanes();
        t_burst();
        t_desel();
        t_sleep();
        wrap_up();
    end
    // Cut a hung run short
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
